// file: logic/mec_pkg.sv
`default_nettype none
package mec_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int GAP_MIN_US = 4;
	localparam int GAP_W = 10;
	localparam logic [GAP_W-1:0] GAP_CYCLES = GAP_W'(GAP_MIN_US * CLK_MHZ);

	// ----------------------------------------------------------------
	// Bus word fields
	// ----------------------------------------------------------------
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 11;
	localparam int TR_BIT = 10;
	localparam int SA_HI = 9;
	localparam int SA_LO = 5;
	localparam int WC_HI = 4;
	localparam int WC_LO = 0;
	localparam int MC_HIGH_BIT = 4;
	localparam int SW_BUSY_BIT = 3;
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	localparam logic [4:0] SA_MODE_LO = 5'h00;
	localparam logic [4:0] SA_MODE_HI = 5'h1F;
	localparam logic [4:0] MC_NB_A = 5'h00;
	localparam logic [4:0] MC_NB_B = 5'h02;
	localparam logic [4:0] MC_NB_C = 5'h10;
	localparam logic [4:0] MC_NB_D = 5'h12;
	localparam logic [4:0] MC_NB_E = 5'h13;
	localparam logic [4:0] WC_ZERO = 5'h00;
	localparam logic [5:0] WC_FULL = 6'h20;
	localparam logic [5:0] WC_ONE = 6'h01;
	localparam logic [5:0] WC_NONE = 6'h00;

	// ----------------------------------------------------------------
	// Word roles reported by the decoder
	// ----------------------------------------------------------------
	localparam logic [1:0] ROLE_CMD = 2'h0;
	localparam logic [1:0] ROLE_STATUS = 2'h1;
	localparam logic [1:0] ROLE_DATA = 2'h2;

	// ----------------------------------------------------------------
	// Message status word layout
	// ----------------------------------------------------------------
	localparam int FLG_WC = 5;
	localparam int FLG_SYNC = 4;
	localparam int FLG_WORD = 3;
	localparam int FLG_PAIR = 2;
	localparam int FLG_SECOND = 1;
	localparam int FLG_CONTENT = 0;
	localparam int STS_RT_PAIR = 11;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_CFG = 8'h00;
	localparam logic [7:0] ADR_MSG_STATUS = 8'h04;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h0C;
	localparam int CFG_EXT_BIT = 0;
	localparam int CFG_GAP_BIT = 12;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
endpackage : mec_pkg
`default_nettype wire

// file: logic/mec_gap_timer.sv
`timescale 1ns/100ps
`default_nettype none
module mec_gap_timer (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_parity_mid,
	input wire logic i_sync_mid,
	output logic o_short
);
	logic [mec_pkg::GAP_W-1:0] cnt;
	logic running;

	// ----------------------------------------------------------------
	// Response time counter
	// ----------------------------------------------------------------
	// The counter saturates so a long idle bus never wraps into a false short gap.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= '0;
			running <= 1'b0;
		end else if (i_parity_mid) begin
			cnt <= '0;
			running <= 1'b1;
		end else if (i_sync_mid) begin
			running <= 1'b0;
		end else if (running && cnt != mec_pkg::GAP_CYCLES) begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_short <= 1'b0;
		end else if (i_sync_mid) begin
			o_short <= running && (cnt < mec_pkg::GAP_CYCLES);
		end
	end

	a_gap_short_seen: assert property (@(posedge i_clk) disable iff (i_rst)
		i_sync_mid && running && cnt < mec_pkg::GAP_CYCLES |=> o_short)
		else $error("short response gap not reported");
endmodule : mec_gap_timer
`default_nettype wire

// file: logic/mec_classifier.sv
`timescale 1ns/100ps
`default_nettype none
module mec_classifier (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_word_valid,
	input wire logic [15:0] i_word_data,
	input wire logic [1:0] i_word_role,
	input wire logic i_word_cmd_sync,
	input wire logic i_word_invalid,
	input wire logic i_parity_mid,
	input wire logic i_sync_mid,
	input wire logic i_resp_timeout,
	input wire logic i_msg_end,
	output logic [15:0] o_msg_status,
	output logic o_irq
);
	typedef enum logic {MEC_IDLE, MEC_ACTIVE} mec_state_t;

	mec_state_t state;
	logic [5:0] flags;
	logic [5:0] next_flags;
	logic [15:0] cmd1;
	logic [15:0] cmd2;
	logic [1:0] ncmd;
	logic [1:0] nstat;
	logic [5:0] ndata;
	logic busy_seen;
	logic timeout_seen;
	logic cfg_ext;
	logic cfg_gap;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic gap_short;
	logic start;
	logic in_msg;
	logic pair;
	logic ending;
	logic wc_bad;
	logic [15:0] next_status;
	logic wb_req;
	logic [1:0] irq_set;

	// ----------------------------------------------------------------
	// Field helpers
	// ----------------------------------------------------------------
	function automatic logic f_is_mode(input logic [4:0] sa);
		f_is_mode = (sa == mec_pkg::SA_MODE_LO) || (sa == mec_pkg::SA_MODE_HI);
	endfunction : f_is_mode

	function automatic logic f_content_bad(input logic [15:0] w);
		logic bc;
		logic tx;
		logic md;
		logic [4:0] mc;
		bc = w[mec_pkg::ADDR_HI:mec_pkg::ADDR_LO] == mec_pkg::BCAST_ADDR;
		tx = w[mec_pkg::TR_BIT];
		md = f_is_mode(w[mec_pkg::SA_HI:mec_pkg::SA_LO]);
		mc = w[mec_pkg::WC_HI:mec_pkg::WC_LO];
		f_content_bad = (bc && tx && !md)
			|| (!tx && md && !mc[mec_pkg::MC_HIGH_BIT])
			|| (bc && tx && md && (mc == mec_pkg::MC_NB_A || mc == mec_pkg::MC_NB_B
			|| mc == mec_pkg::MC_NB_C || mc == mec_pkg::MC_NB_D
			|| mc == mec_pkg::MC_NB_E));
	endfunction : f_content_bad

	function automatic logic [5:0] f_expect(input logic [15:0] w);
		logic [4:0] wc;
		wc = w[mec_pkg::WC_HI:mec_pkg::WC_LO];
		if (f_is_mode(w[mec_pkg::SA_HI:mec_pkg::SA_LO])) begin
			f_expect = wc[mec_pkg::MC_HIGH_BIT] ? mec_pkg::WC_ONE : mec_pkg::WC_NONE;
		end else if (wc == mec_pkg::WC_ZERO) begin
			f_expect = mec_pkg::WC_FULL;
		end else begin
			f_expect = {1'b0, wc};
		end
	endfunction : f_expect

	function automatic logic [4:0] f_addr(input logic [15:0] w);
		f_addr = w[mec_pkg::ADDR_HI:mec_pkg::ADDR_LO];
	endfunction : f_addr

	// ----------------------------------------------------------------
	// Response gap measurement
	// ----------------------------------------------------------------
	mec_gap_timer u_gap (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_parity_mid(i_parity_mid),
		.i_sync_mid(i_sync_mid),
		.o_short(gap_short)
	);

	// ----------------------------------------------------------------
	// Message framing
	// ----------------------------------------------------------------
	assign start = i_word_valid && state == MEC_IDLE && i_word_role == mec_pkg::ROLE_CMD;
	assign in_msg = i_word_valid && (start || state == MEC_ACTIVE);
	assign pair = ncmd == 2'h2;
	assign ending = i_msg_end && state == MEC_ACTIVE;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= MEC_IDLE;
		end else begin
			case (state)
				MEC_IDLE: begin
					if (start) begin
						state <= MEC_ACTIVE;
					end
				end
				MEC_ACTIVE: begin
					if (i_msg_end) begin
						state <= MEC_IDLE;
					end
				end
				default: begin
					state <= MEC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Per-word classification
	// ----------------------------------------------------------------
	always_comb begin
		next_flags = start ? 6'h00 : flags;
		if (in_msg) begin
			if ((i_word_role == mec_pkg::ROLE_CMD && !i_word_cmd_sync)
				|| (i_word_role == mec_pkg::ROLE_DATA && i_word_cmd_sync)
				|| (i_word_role == mec_pkg::ROLE_STATUS && !i_word_cmd_sync)) begin
				next_flags[mec_pkg::FLG_SYNC] = 1'b1;
			end
			if (i_word_invalid) begin
				next_flags[mec_pkg::FLG_WORD] = 1'b1;
			end
			if (cfg_ext) begin
				if (i_word_role == mec_pkg::ROLE_CMD && f_content_bad(i_word_data)) begin
					next_flags[mec_pkg::FLG_CONTENT] = 1'b1;
				end
				// Only a command that directly follows the first one makes a pair.
				if (i_word_role == mec_pkg::ROLE_CMD && !start && ncmd == 2'h1
					&& nstat == 2'h0 && ndata == 6'h00) begin
					if (!i_word_data[mec_pkg::TR_BIT]
						|| f_is_mode(i_word_data[mec_pkg::SA_HI:mec_pkg::SA_LO])
						|| f_addr(i_word_data) == f_addr(cmd1)) begin
						next_flags[mec_pkg::FLG_SECOND] = 1'b1;
					end
				end
				if (i_word_role == mec_pkg::ROLE_STATUS && pair) begin
					if (cfg_gap && gap_short) begin
						next_flags[mec_pkg::FLG_PAIR] = 1'b1;
					end
					if (i_word_invalid || !i_word_cmd_sync) begin
						next_flags[mec_pkg::FLG_PAIR] = 1'b1;
					end
					// The transmitter answers first, then the receiver.
					if (f_addr(i_word_data) != f_addr(nstat == 2'h0 ? cmd2 : cmd1)) begin
						next_flags[mec_pkg::FLG_PAIR] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags <= 6'h00;
		end else begin
			flags <= next_flags;
		end
	end

	// ----------------------------------------------------------------
	// Message context
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmd1 <= 16'h0000;
			cmd2 <= 16'h0000;
			ncmd <= 2'h0;
			nstat <= 2'h0;
			ndata <= 6'h00;
			busy_seen <= 1'b0;
			timeout_seen <= 1'b0;
		end else if (start) begin
			cmd1 <= i_word_data;
			ncmd <= 2'h1;
			nstat <= 2'h0;
			ndata <= 6'h00;
			busy_seen <= 1'b0;
			timeout_seen <= 1'b0;
		end else if (state == MEC_ACTIVE) begin
			if (i_resp_timeout) begin
				timeout_seen <= 1'b1;
			end
			if (in_msg && i_word_role == mec_pkg::ROLE_CMD && ncmd == 2'h1
				&& nstat == 2'h0 && ndata == 6'h00) begin
				cmd2 <= i_word_data;
				ncmd <= 2'h2;
			end
			if (in_msg && i_word_role == mec_pkg::ROLE_STATUS) begin
				if (nstat != 2'h3) begin
					nstat <= nstat + 2'h1;
				end
				if (i_word_data[mec_pkg::SW_BUSY_BIT]) begin
					busy_seen <= 1'b1;
				end
			end
			if (in_msg && i_word_role == mec_pkg::ROLE_DATA && ndata != 6'h3F) begin
				ndata <= ndata + 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Stored status word
	// ----------------------------------------------------------------
	always_comb begin
		wc_bad = ndata != f_expect(cmd1)
			&& !busy_seen
			&& !(timeout_seen && (pair ? cmd2[mec_pkg::TR_BIT] : cmd1[mec_pkg::TR_BIT]));
		next_status = 16'h0000;
		next_status[5:0] = flags;
		next_status[mec_pkg::FLG_WC] = wc_bad;
		next_status[mec_pkg::STS_RT_PAIR] = pair;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_msg_status <= 16'h0000;
		end else if (ending) begin
			o_msg_status <= next_status;
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Every request is answered one cycle later, unmapped ones with zero data.
	assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= wb_req;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wb_dat <= 32'h00000000;
		end else if (wb_req && !i_wb_we) begin
			o_wb_dat <= 32'h00000000;
			case (i_wb_adr)
				mec_pkg::ADR_CFG: begin
					o_wb_dat[mec_pkg::CFG_EXT_BIT] <= cfg_ext;
					o_wb_dat[mec_pkg::CFG_GAP_BIT] <= cfg_gap;
				end
				mec_pkg::ADR_MSG_STATUS: begin
					o_wb_dat[15:0] <= o_msg_status;
				end
				mec_pkg::ADR_IRQ_STATUS: begin
					o_wb_dat[1:0] <= irq_stat;
				end
				mec_pkg::ADR_IRQ_MASK: begin
					o_wb_dat[1:0] <= irq_mask;
				end
				default: begin
					o_wb_dat <= 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_ext <= 1'b0;
			cfg_gap <= 1'b0;
			irq_mask <= 2'h0;
		end else if (wb_req && i_wb_we) begin
			if (i_wb_adr == mec_pkg::ADR_CFG && i_wb_sel[0]) begin
				cfg_ext <= i_wb_dat[mec_pkg::CFG_EXT_BIT];
			end
			if (i_wb_adr == mec_pkg::ADR_CFG && i_wb_sel[1]) begin
				cfg_gap <= i_wb_dat[mec_pkg::CFG_GAP_BIT];
			end
			if (i_wb_adr == mec_pkg::ADR_IRQ_MASK && i_wb_sel[0]) begin
				irq_mask <= i_wb_dat[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_comb begin
		irq_set = 2'h0;
		irq_set[mec_pkg::IRQ_DONE_BIT] = ending;
		irq_set[mec_pkg::IRQ_ERR_BIT] = ending && (next_status[5:0] != 6'h00);
	end

	// A new event in the cycle of the clearing read stays pending.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_stat <= 2'h0;
		end else if (wb_req && !i_wb_we && i_wb_adr == mec_pkg::ADR_IRQ_STATUS) begin
			irq_stat <= irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_start_clears_pair: assert property (@(posedge i_clk) disable iff (i_rst)
		start |=> !flags[mec_pkg::FLG_PAIR] && !flags[mec_pkg::FLG_SECOND])
		else $error("pair flags survived message start");

	a_end_stores_flags: assert property (@(posedge i_clk) disable iff (i_rst)
		ending |=> o_msg_status[4:0] == $past(flags[4:0]))
		else $error("stored status differs from running flags");

	a_ext_gates_flags: assert property (@(posedge i_clk) disable iff (i_rst)
		!cfg_ext && !start |=> flags[2:0] == $past(flags[2:0]))
		else $error("extended flags changed while disabled");

	a_invalid_word: assert property (@(posedge i_clk) disable iff (i_rst)
		in_msg && i_word_invalid |=> flags[mec_pkg::FLG_WORD])
		else $error("invalid word not flagged");

	a_data_sync_kind: assert property (@(posedge i_clk) disable iff (i_rst)
		in_msg && i_word_role == mec_pkg::ROLE_DATA && i_word_cmd_sync
		|=> flags[mec_pkg::FLG_SYNC])
		else $error("data word with command sync not flagged");

	a_second_cmd_rx: assert property (@(posedge i_clk) disable iff (i_rst)
		in_msg && cfg_ext && !start && i_word_role == mec_pkg::ROLE_CMD && ncmd == 2'h1
		&& nstat == 2'h0 && ndata == 6'h00 && !i_word_data[mec_pkg::TR_BIT]
		|=> flags[mec_pkg::FLG_SECOND])
		else $error("receive second command not flagged");

	a_bcast_tx_data: assert property (@(posedge i_clk) disable iff (i_rst)
		in_msg && cfg_ext && i_word_role == mec_pkg::ROLE_CMD
		&& f_addr(i_word_data) == mec_pkg::BCAST_ADDR && i_word_data[mec_pkg::TR_BIT]
		&& !f_is_mode(i_word_data[mec_pkg::SA_HI:mec_pkg::SA_LO])
		|=> flags[mec_pkg::FLG_CONTENT])
		else $error("broadcast transmit command not flagged");

	a_rt_pair_mark: assert property (@(posedge i_clk) disable iff (i_rst)
		ending && pair |=> o_msg_status[mec_pkg::STS_RT_PAIR])
		else $error("RT pair message not marked");

	a_busy_no_count: assert property (@(posedge i_clk) disable iff (i_rst)
		ending && busy_seen |=> !o_msg_status[mec_pkg::FLG_WC])
		else $error("count mismatch flagged despite busy");

	a_irq_follows: assert property (@(posedge i_clk) disable iff (i_rst)
		ending && irq_mask[mec_pkg::IRQ_DONE_BIT] |=> ##1 o_irq)
		else $error("interrupt did not follow message end");
endmodule : mec_classifier
`default_nettype wire

// file: test/mec_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Bus controller and remote terminals as seen through the decoder
// ----------------------------------------------------------------
// A word is framed as mid-sync, mid-parity, then the decoded word.
// Idle lines show the inverse of the last word, so nothing passes
// by accident when the classifier looks at a word that is not valid.
module mec_bus_model (
	input wire logic i_clk,
	output logic o_word_valid,
	output logic [15:0] o_word_data,
	output logic [1:0] o_word_role,
	output logic o_word_cmd_sync,
	output logic o_word_invalid,
	output logic o_parity_mid,
	output logic o_sync_mid,
	output logic o_resp_timeout,
	output logic o_msg_end
);
	initial begin
		o_word_valid = 1'b0;
		o_word_data = 16'h0000;
		o_word_role = 2'h0;
		o_word_cmd_sync = 1'b0;
		o_word_invalid = 1'b0;
		o_parity_mid = 1'b0;
		o_sync_mid = 1'b0;
		o_resp_timeout = 1'b0;
		o_msg_end = 1'b0;
	end

	// The gap argument lets a terminal answer promptly or slowly.
	task automatic word(input int g, input logic [15:0] d, input logic [1:0] r,
		input logic cs, input logic bad);
		repeat (g) @(posedge i_clk);
		o_sync_mid <= 1'b1;
		@(posedge i_clk);
		o_sync_mid <= 1'b0;
		o_parity_mid <= 1'b1;
		@(posedge i_clk);
		o_parity_mid <= 1'b0;
		o_word_valid <= 1'b1;
		o_word_data <= d;
		o_word_role <= r;
		o_word_cmd_sync <= cs;
		o_word_invalid <= bad;
		@(posedge i_clk);
		o_word_valid <= 1'b0;
		o_word_data <= ~d;
		o_word_role <= ~r;
		o_word_cmd_sync <= ~cs;
		o_word_invalid <= ~bad;
	endtask : word

	task automatic pulse_end();
		@(posedge i_clk);
		o_msg_end <= 1'b1;
		@(posedge i_clk);
		o_msg_end <= 1'b0;
	endtask : pulse_end

	task automatic pulse_timeout();
		@(posedge i_clk);
		o_resp_timeout <= 1'b1;
		@(posedge i_clk);
		o_resp_timeout <= 1'b0;
	endtask : pulse_timeout
endmodule : mec_bus_model
`default_nettype wire

// file: test/monitor_message_error_classifier_test.sv
`timescale 1ns/100ps
`default_nettype none
module monitor_message_error_classifier_test;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000, q;
	logic [31:0] o_wb_dat;
	logic o_wb_ack, o_irq;
	logic [15:0] o_msg_status;
	logic wv, csync, winv, pmid, smid, tmo, mend;
	logic [15:0] wd;
	logic [1:0] wr;
	int error_cnt = 0;
	int samples_checked = 0;
	// Column 16 is the expected content flag for the command word below it.
	logic [16:0] tbl [12] = '{17'h1FC21, 17'h1FFC1, 17'h0F421, 17'h10800, 17'h10BEF,
		17'h00810, 17'h1FC00, 17'h1FC02, 17'h1FFF0, 17'h1FC12, 17'h1FC13, 17'h0FC01};

	always #2 i_clk = ~i_clk;

	mec_classifier dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack), .i_word_valid(wv), .i_word_data(wd), .i_word_role(wr),
		.i_word_cmd_sync(csync), .i_word_invalid(winv), .i_parity_mid(pmid),
		.i_sync_mid(smid), .i_resp_timeout(tmo), .i_msg_end(mend),
		.o_msg_status(o_msg_status), .o_irq(o_irq));
	mec_bus_model bm (.i_clk(i_clk), .o_word_valid(wv), .o_word_data(wd), .o_word_role(wr),
		.o_word_cmd_sync(csync), .o_word_invalid(winv), .o_parity_mid(pmid),
		.o_sync_mid(smid), .o_resp_timeout(tmo), .o_msg_end(mend));

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	// The request stands until ack is seen high at a rising edge, where read data is taken.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		q = o_wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic msg(input string name, input logic [15:0] mask, input logic [15:0] exp);
		bm.pulse_end();
		@(posedge i_clk);
		#1;
		cmp(name, {16'h0000, exp}, {16'h0000, o_msg_status & mask});
	endtask : msg

	task automatic rx(input int nd, input logic busy, input logic [3:0] f);
		bm.word(2, 16'h0822, mec_pkg::ROLE_CMD, ~f[0], 1'b0);
		for (int i = 0; i < nd; i++) bm.word(2, 16'hA5C3 ^ 16'(i), mec_pkg::ROLE_DATA, f[1], f[3]);
		bm.word(2, {5'h01, 7'h00, busy, 3'h0}, mec_pkg::ROLE_STATUS, ~f[2], 1'b0);
	endtask : rx

	task automatic rt(input logic [15:0] c2, input logic [15:0] s1, input logic bad, input int g);
		bm.word(2, 16'h0821, mec_pkg::ROLE_CMD, 1'b1, 1'b0);
		bm.word(0, c2, mec_pkg::ROLE_CMD, 1'b1, 1'b0);
		bm.word(g, s1, mec_pkg::ROLE_STATUS, 1'b1, bad);
		bm.word(2, 16'h5A3C, mec_pkg::ROLE_DATA, 1'b0, 1'b0);
		bm.word(g, 16'h0800, mec_pkg::ROLE_STATUS, 1'b1, 1'b0);
	endtask : rt

	initial begin
		#100000;
		error_cnt++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		wb(1'b0, mec_pkg::ADR_CFG, 32'h0);
		cmp("cfg_reset", 32'h0, q);
		wb(1'b0, mec_pkg::ADR_IRQ_MASK, 32'h0);
		cmp("mask_reset", 32'h0, q);
		wb(1'b0, 8'h10, 32'h0);
		cmp("unmapped", 32'h0, q);
		$display("test registers done");
		rx(2, 1'b0, 4'h0);
		msg("wc_good", 16'hFFFF, 16'h0000);
		rx(1, 1'b0, 4'h0);
		msg("wc_short", 16'hFFFF, 16'h0020);
		wb(1'b0, mec_pkg::ADR_MSG_STATUS, 32'h0);
		cmp("msg_status_reg", 32'h20, q);
		wb(1'b1, mec_pkg::ADR_MSG_STATUS, 32'hFFFF);
		wb(1'b0, mec_pkg::ADR_MSG_STATUS, 32'h0);
		cmp("msg_status_ro", 32'h20, q);
		wb(1'b1, mec_pkg::ADR_CFG, 32'h1);
		rx(1, 1'b1, 4'h0);
		msg("wc_busy", 16'hFFFF, 16'h0000);
		bm.word(2, 16'h0C22, mec_pkg::ROLE_CMD, 1'b1, 1'b0);
		bm.pulse_timeout();
		msg("wc_timeout", 16'h0020, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			rx(2, 1'b0, 4'(1 << k));
			msg("sync_kind", 16'h0018, 16'h0010);
		end
		rx(2, 1'b0, 4'h8);
		msg("invalid_word", 16'h0018, 16'h0008);
		$display("test word checks done");
		rt(16'h1421, 16'h1000, 1'b0, 2);
		msg("pair_good", 16'h0807, 16'h0800);
		rt(16'h1421, 16'h1800, 1'b0, 2);
		msg("pair_addr", 16'h0807, 16'h0804);
		rt(16'h1421, 16'h1000, 1'b1, 2);
		msg("pair_bad_sts", 16'h0807, 16'h0804);
		rt(16'h1021, 16'h1000, 1'b0, 2);
		msg("second_rx", 16'h0002, 16'h0002);
		rt(16'h1411, 16'h1000, 1'b0, 2);
		msg("second_sa0", 16'h0002, 16'h0002);
		rt(16'h17F1, 16'h1000, 1'b0, 2);
		msg("second_sa31", 16'h0002, 16'h0002);
		rt(16'h0C21, 16'h0800, 1'b0, 2);
		msg("second_same", 16'h0002, 16'h0002);
		wb(1'b1, mec_pkg::ADR_CFG, 32'h1001);
		wb(1'b0, mec_pkg::ADR_CFG, 32'h0);
		cmp("cfg_rw", 32'h1001, q);
		wb(1'b0, 8'h10, 32'h0);
		cmp("unmapped_zero", 32'h0, q);
		rt(16'h1421, 16'h1000, 1'b0, 2);
		msg("gap_short", 16'h0004, 16'h0004);
		rt(16'h1421, 16'h1000, 1'b0, 1000);
		msg("gap_long", 16'h0004, 16'h0000);
		$display("test pair checks done");
		for (int k = 0; k < 12; k++) begin
			bm.word(2, tbl[k][15:0], mec_pkg::ROLE_CMD, 1'b1, 1'b0);
			msg("content", 16'h0001, {15'h0000, tbl[k][16]});
		end
		wb(1'b1, mec_pkg::ADR_CFG, 32'h0);
		bm.word(2, 16'hFC21, mec_pkg::ROLE_CMD, 1'b1, 1'b0);
		msg("ext_off_content", 16'h0007, 16'h0000);
		rt(16'h0C21, 16'h1800, 1'b0, 2);
		msg("ext_off_pair", 16'h0807, 16'h0800);
		$display("test content done");
		wb(1'b0, mec_pkg::ADR_IRQ_STATUS, 32'h0);
		wb(1'b1, mec_pkg::ADR_IRQ_MASK, 32'h3);
		wb(1'b0, mec_pkg::ADR_IRQ_MASK, 32'h0);
		cmp("mask_rw", 32'h3, q);
		#1;
		cmp("irq_clear", 32'h0, {31'h0, o_irq});
		rx(1, 1'b0, 4'h0);
		msg("irq_msg", 16'h0020, 16'h0020);
		@(posedge i_clk);
		#1;
		cmp("irq_high", 32'h1, {31'h0, o_irq});
		wb(1'b0, mec_pkg::ADR_IRQ_STATUS, 32'h0);
		cmp("irq_status", 32'h3, q);
		repeat (2) @(posedge i_clk);
		#1;
		cmp("irq_low", 32'h0, {31'h0, o_irq});
		wb(1'b1, mec_pkg::ADR_IRQ_MASK, 32'h2);
		rx(2, 1'b0, 4'h0);
		msg("irq_clean", 16'h0020, 16'h0000);
		@(posedge i_clk);
		#1;
		cmp("irq_masked", 32'h0, {31'h0, o_irq});
		wb(1'b0, mec_pkg::ADR_IRQ_STATUS, 32'h0);
		cmp("irq_done_only", 32'h1, q);
		$display("test interrupts done");
		conclude();
	end
endmodule : monitor_message_error_classifier_test
`default_nettype wire
